// ---- src/tsba_arbiter.sv ----
// tsba_arbiter: secondary bus arbiter with its control register
// assumes req/gnt active high, bus idle flag supplied by the bus interface logic
`timescale 1ns/100ps
`default_nettype none
module tsba_arbiter (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire tsba_pkg::tsba_cfg_t cfg,
   output logic [7:0]             cfg_rdata,
   input  wire logic [5:0]        ext_req,
   input  wire logic              bridge_req,
   input  wire logic              bus_idle,
   output logic [5:0]             ext_gnt,
   output logic                   bridge_gnt
);
   localparam int W = $clog2(tsba_pkg::N_PARTY);

   logic [7:0]   ctrl_reg;
   logic [W-1:0] last_hi_reg;
   logic [W-1:0] last_lo_reg;
   logic         lo_turn_reg;
   logic [W-1:0] owner_reg;
   logic [6:0]   req_all;
   logic [6:0]   req_hi;
   logic [6:0]   req_lo;
   logic         any_hi;
   logic         any_lo;
   logic [W-1:0] pick_hi;
   logic [W-1:0] pick_lo;
   logic [W-1:0] win;
   logic         win_lo;
   logic         win_ok;
   logic [6:0]   gnt_next;

   // control register, reset puts only the bridge high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg <= tsba_pkg::CTRL_RESET;
      end else if (cfg.wr && cfg.addr == tsba_pkg::CTRL_OFFSET) begin
         ctrl_reg <= cfg.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_rdata <= '0;
      end else begin
         cfg_rdata <= (cfg.addr == tsba_pkg::CTRL_OFFSET) ? ctrl_reg : '0;
      end
   end

   assign req_all = {bridge_req, ext_req};
   assign req_hi  = req_all & ctrl_reg[6:0];
   assign req_lo  = req_all & ~ctrl_reg[6:0];

   tsba_rr_pick #(.N(tsba_pkg::N_PARTY)) u_hi (
      .req  (req_hi),
      .last (last_hi_reg),
      .any  (any_hi),
      .pick (pick_hi)
   );
   tsba_rr_pick #(.N(tsba_pkg::N_PARTY)) u_lo (
      .req  (req_lo),
      .last (last_lo_reg),
      .any  (any_lo),
      .pick (pick_lo)
   );

   // low tier alternates with the high tier: after each high grant, a low requester wins the next one
   always_comb begin
      win_lo = any_lo && (!any_hi || lo_turn_reg);
      win_ok = any_hi || any_lo;
      win    = win_lo ? pick_lo : pick_hi;
      if (!win_ok) begin
         win = ctrl_reg[tsba_pkg::CTRL_PARK_BIT] ? W'(tsba_pkg::BRIDGE_IDX) : owner_reg;
      end
   end

   // grant only changes while the bus is idle so an owner is never cut off mid-transfer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         owner_reg   <= W'(tsba_pkg::BRIDGE_IDX);
         last_hi_reg <= W'(tsba_pkg::BRIDGE_IDX);
         last_lo_reg <= W'(tsba_pkg::BRIDGE_IDX);
         lo_turn_reg <= 1'b0;
      end else if (bus_idle) begin
         owner_reg <= win;
         if (win_ok && win_lo) begin
            last_lo_reg <= win;
            lo_turn_reg <= 1'b0;
         end else if (win_ok) begin
            last_hi_reg <= win;
            lo_turn_reg <= 1'b1;
         end
      end
   end

   always_comb begin
      gnt_next = '0;
      gnt_next[bus_idle ? win : owner_reg] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_gnt    <= '0;
         bridge_gnt <= 1'b0;
      end else begin
         ext_gnt    <= gnt_next[5:0];
         bridge_gnt <= gnt_next[tsba_pkg::BRIDGE_IDX];
      end
   end
endmodule : tsba_arbiter
`default_nettype wire

// ---- src/tsba_pkg.sv ----
// tsba_pkg: constants and types for the two-tier secondary bus arbiter
// assumes a configuration-space access path that supplies byte writes at the control offset
// Behaviour
// - arbitrate the secondary bus by rotation within a high tier and a low tier.
// - after reset only the bridge sits high; control reads 40h.
// - park bit set parks the idle bus on the bridge.
// - park bit clear parks the idle bus on the last owner.
// - bridge tier bit selects low (0) or high (1) tier for the bridge.
// - control bit n places external master n low (0) or high (1).
package tsba_pkg;
   localparam int          N_EXT          = 6;
   localparam int          N_PARTY        = 7;              // six masters plus the bridge at index 6
   localparam int          BRIDGE_IDX     = 6;
   localparam logic [7:0]  CTRL_OFFSET    = 8'hdc;
   localparam logic [7:0]  CTRL_RESET     = 8'h40;
   localparam int          CTRL_PARK_BIT  = 7;
   localparam int          CTRL_BTIER_BIT = 6;

   typedef struct packed {
      logic       park_on_bridge;
      logic [6:0] tier_high;     // bit 6 bridge, bits 5:0 masters
   } tsba_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tsba_cfg_t;
endpackage : tsba_pkg

// ---- src/tsba_rr_pick.sv ----
// tsba_rr_pick: round-robin picker over a request vector, starting after last winner
// assumes requests are already filtered to one tier
`timescale 1ns/100ps
`default_nettype none
module tsba_rr_pick #(
   parameter int N = 7
) (
   input  wire logic [N-1:0]         req,
   input  wire logic [$clog2(N)-1:0] last,
   output logic                      any,
   output logic [$clog2(N)-1:0]      pick
);
   always_comb begin
      int idx;
      idx  = 0;
      any  = 1'b0;
      pick = '0;
      for (int k = 1; k <= N; k++) begin
         idx = (int'(last) + k) % N;
         if (!any && req[idx]) begin
            any  = 1'b1;
            pick = idx[$clog2(N)-1:0];
         end
      end
   end
endmodule : tsba_rr_pick
`default_nettype wire

// ---- sim/tsba_chk.sv ----
// tsba_chk: port assertions for the arbiter
// assumes a bind onto tsba_arbiter, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tsba_chk (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire tsba_pkg::tsba_cfg_t cfg,
   input wire logic [7:0]          cfg_rdata,
   input wire logic [5:0]          ext_req,
   input wire logic                bridge_req,
   input wire logic                bus_idle,
   input wire logic [5:0]          ext_gnt,
   input wire logic                bridge_gnt
);
   wire logic [6:0] r = {bridge_req, ext_req};
   wire logic [6:0] g = {bridge_gnt, ext_gnt};
   logic      [7:0] c_reg;
   // shadow of the control byte, so the park, last-owner and tier properties see the control in force
   always_ff @(posedge clk) c_reg <= !rst_n ? 8'h40 : (cfg.wr && cfg.addr == 8'hdc) ? cfg.wdata : c_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_q; bus_idle && r == 7'h00; endsequence
   property p_one; $onehot0(g); endproperty
   a_one: assert property (p_one) else $error("two grants");
   property p_rst; $past(!rst_n) && cfg.addr == 8'hdc |=> cfg_rdata == 8'h40; endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_park; c_reg[7] ##0 s_q |=> bridge_gnt; endproperty
   a_park: assert property (p_park) else $error("not parked on bridge");
   property p_last; !c_reg[7] && g != 7'h00 ##0 s_q |=> g == $past(g); endproperty
   a_last: assert property (p_last) else $error("left last owner");
   property p_serve; bus_idle && r != 7'h00 |=> (g & $past(r)) != 7'h00; endproperty
   a_serve: assert property (p_serve) else $error("requester not served");
   property p_hold; !bus_idle |=> $stable(g); endproperty
   a_hold: assert property (p_hold) else $error("grant moved on busy bus");
   property p_tier; bus_idle && |(g & ~c_reg[6:0]) && |(r & c_reg[6:0]) |=> |(g & c_reg[6:0]); endproperty
   a_tier: assert property (p_tier) else $error("low tier served twice");
endmodule : tsba_chk
bind tsba_arbiter tsba_chk i_chk (.*);
`default_nettype wire

// ---- sim/tsba_master_model.sv ----
// tsba_master_model: six far-side bus masters
// assumes grants sampled on the arbiter clock
`timescale 1ns/100ps
`default_nettype none
module tsba_master_model (
   input  wire logic       clk,
   input  wire logic [5:0] want,
   input  wire logic [5:0] ext_gnt,
   output var  logic [5:0] ext_req = 6'h00
);
   // a granted master drops its request, so rotation shows at once
   always @(posedge clk) ext_req <= want & ~ext_gnt;
endmodule : tsba_master_model
`default_nettype wire

// ---- sim/two_tier_secondary_bus_arbiter_tb_top.sv ----
// two_tier_secondary_bus_arbiter_tb_top: directed scenarios
// assumes tsba_chk is bound onto the design
`timescale 1ns/100ps
`default_nettype none
module two_tier_secondary_bus_arbiter_tb_top;
   logic                clk = 0, rst_n = 0, bridge_req = 0, bus_idle = 1, bridge_gnt;
   logic [5:0]          want = 6'h00, ext_req, ext_gnt;
   logic [7:0]          cfg_rdata, h;
   tsba_pkg::tsba_cfg_t cfg = '{1'b0, 8'hdc, 8'h00};
   int                  miscompares = 0, checks_done = 0;
   wire logic [6:0]     g = {bridge_gnt, ext_gnt};
   always #4 clk = ~clk;
   tsba_arbiter i_dut (.*);
   tsba_master_model i_m (.*);
   task automatic step(int n); repeat (n) @(posedge clk); #1; endtask : step
   task automatic cmp(string s, logic [7:0] e, logic [7:0] v);
      checks_done++;
      if (v !== e) begin miscompares++; $display("MISMATCH %s exp %h seen %h", s, e, v); end
   endtask : cmp
   task automatic wr(logic [7:0] d); cfg = '{1'b1, 8'hdc, d}; step(1); cfg.wr = 0; endtask : wr
   task automatic t_grant_park;
      want = 6'h04; step(2); want = 6'h00; cmp("grant", 8'h04, g);
      step(3); cmp("parked", 8'h04, g);
   endtask : t_grant_park
   task automatic t_bridge_park;
      wr(8'hc0); step(2); cmp("ctrl", 8'hc0, cfg_rdata);
      cmp("bpark", 8'h40, g);
   endtask : t_bridge_park
   task automatic t_tiers;
      wr(8'h01); bridge_req = 1; want = 6'h03; step(9); bus_idle = 0; h = g;
      step(3); cmp("hold", h, g);
      bus_idle = 1; bridge_req = 0; want = 6'h00;
   endtask : t_tiers
   // runs straight after a reset, so the low-tier turn flag is known clear
   task automatic t_prio;
      want = 6'h01; step(1); bridge_req = 1; step(1); cmp("bridge high", 8'h40, g);
      bridge_req = 0; step(1); cmp("low served", 8'h01, g);
      want = 6'h00; step(1);
      wr(8'h08); want = 6'h0a; step(2); cmp("m3 high", 8'h08, g);
      step(1); cmp("low slot", 8'h02, g);
      want = 6'h00; step(2);
   endtask : t_prio
   task automatic finish_test;
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      step(6); rst_n = 1; step(1); cmp("reset", 8'h40, cfg_rdata);
      t_grant_park(); t_bridge_park(); t_tiers();
      rst_n = 0; step(2); rst_n = 1; step(1); cmp("rereset", 8'h40, cfg_rdata);
      t_prio();
      finish_test();
   end
endmodule : two_tier_secondary_bus_arbiter_tb_top
`default_nettype wire
